/* ebf_defines.svh */
`ifndef EBF_DEFINES_SVH
`define EBF_DEFINES_SVH
// array shape: 512 words of two 9-bit lanes
`define EBF_LANE_W 9
`define EBF_LANES 2
`define EBF_DATA_W 18
`define EBF_ADDR_W 9
`define EBF_PTR_W 10
`define EBF_DEPTH 512
`define EBF_FULL_LEVEL 10'h200
// select patterns, bit 2 of the fifo selects is the gate input
`define EBF_CS_MATCH 3'h7
`define EBF_CSW_MATCH 3'h3
`define EBF_CSR_MATCH 3'h3
// read data staging buffer
`define EBF_BUF_DEPTH 4
`endif

/* ebf_pkg.sv */
package ebf_pkg;
`include "ebf_defines.svh"
    typedef enum logic [1:0] {
        ebf_single,
        ebf_true_dual,
        ebf_pseudo_dual,
        ebf_fifo
    } ebf_mode_t;
    typedef struct packed {
        logic we;
        logic out_en;
        logic [`EBF_LANES-1:0] be;
        logic [`EBF_ADDR_W-1:0] addr;
        logic [`EBF_DATA_W-1:0] din;
    } ebf_req_t;
endpackage

/* ebf_stream_if.sv */
`timescale 1ns/100ps
interface ebf_stream_if #(parameter int W = 18) ();
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport store (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

/* ebf_sync3.sv */
`timescale 1ns/100ps
module ebf_sync3 #(
    parameter int W = 4
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);
    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    ////////////////////////////////////////////////////////////////
    // ff1 feeds ff2 only; a level moves once ff2 and ff3 agree
    always_ff @(posedge mclk) begin
        if (reset) begin
            ff1 <= '0;
            ff2 <= '0;
            ff3 <= '0;
            level <= '0;
        end else if (clk_en) begin
            ff1 <= pin;
            ff2 <= ff1;
            ff3 <= ff2;
            level <= (~(ff2 ^ ff3) & ff2) | ((ff2 ^ ff3) & level);
        end
    end
endmodule

/* ebf_stream_fifo.sv */
`timescale 1ns/100ps
module ebf_stream_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    ebf_stream_if.store s
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic push;
    logic pop;
    ////////////////////////////////////////////////////////////////
    // honest flags from the occupancy count
    assign push = s.in_valid & s.in_ready;
    assign pop = s.out_valid & s.out_ready;
    assign s.in_ready = (cnt != (AW+1)'(DEPTH));
    assign s.out_valid = (cnt != '0);
    assign s.out_data = mem[rp];
    // pointers wrap naturally, depth is a power of two
    always_ff @(posedge mclk) begin
        if (reset) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
        end else if (clk_en) begin
            if (push) begin
                wp <= wp + 1'b1;
            end
            if (pop) begin
                rp <= rp + 1'b1;
            end
            cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
    // storage, no reset needed on data
    always_ff @(posedge mclk) begin
        if (clk_en && push) begin
            mem[wp] <= s.in_data;
        end
    end
endmodule

/* ebf_block_ram.sv */
// Function
// - 9-kbit array; port A and B inputs and all outputs pass through registers inside the block; FIFO inputs act on the array directly
// - configurable as single-port, true dual-port, pseudo dual-port or FIFO
// - dual-port modes give ports A and B, each fully independent
// - FIFO mode has a separate write port and read port
// - FIFO write and read sides each run from their own clock
// - write and read chip selects gate their sides; inactive select ignores access
// - output read enable decides when registered read data updates
// - full gate input behaves as third write select bit, blocking writes
// - empty gate input behaves as third read select bit, blocking reads
// - full and almost-full flags report write-side fill level
// - empty and almost-empty flags report read-side fill level
// - read-pointer reset clears only the read pointer
`timescale 1ns/100ps
`include "ebf_defines.svh"
module ebf_block_ram (
    input wire logic mclk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic [1:0] mode_sel,
    input wire logic a_clk,
    input wire logic a_ce,
    input wire logic a_output_reg_clk_en,
    input wire logic a_rst,
    input wire logic a_we,
    input wire logic [2:0] a_cs,
    input wire logic [1:0] a_byte_lane_en,
    input wire logic [8:0] a_addr,
    input wire logic [17:0] a_write_data,
    output logic [17:0] a_dout,
    input wire logic b_clk,
    input wire logic b_ce,
    input wire logic b_output_reg_clk_en,
    input wire logic b_rst,
    input wire logic b_we,
    input wire logic [2:0] b_cs,
    input wire logic [1:0] b_byte_lane_en,
    input wire logic [8:0] b_addr,
    input wire logic [17:0] b_write_data,
    output logic [17:0] b_dout,
    input wire logic wr_clk,
    input wire logic rd_clk,
    input wire logic [1:0] wr_port_select,
    input wire logic full_in_gate,
    input wire logic [1:0] rd_port_select,
    input wire logic empty_in_gate,
    input wire logic fifo_we,
    input wire logic fifo_re,
    input wire logic [17:0] write_data,
    input wire logic out_read_en,
    input wire logic rd_ptr_reset,
    input wire logic [9:0] af_level,
    input wire logic [9:0] ae_level,
    output logic [17:0] read_data,
    output logic read_valid,
    output logic full_flag,
    output logic almost_full_flag,
    output logic empty_flag,
    output logic almost_empty_flag
);
    localparam int LW = `EBF_LANE_W;
    ebf_pkg::ebf_mode_t mode_r;
    logic [3:0] pin_level;
    logic [3:0] pin_prev;
    logic [3:0] pin_edge;
    logic [1:0] p_edge;
    logic [1:0] p_ce;
    logic [1:0] p_out_en;
    logic [1:0] p_rst;
    logic [1:0] p_we;
    logic [1:0][2:0] p_cs;
    logic [1:0][1:0] p_be;
    logic [1:0][8:0] p_addr;
    logic [1:0][17:0] p_din;
    logic [1:0] port_on;
    logic [1:0] port_wr;
    logic [1:0] port_rd;
    wire [1:0][17:0] port_raw;
    wire [17:0] fifo_raw;
    logic fifo_mode;
    logic wr_edge;
    logic rd_edge;
    logic wr_cs_ok;
    logic rd_cs_ok;
    logic fifo_wr_go;
    logic fifo_rd_go;
    logic rd_pend;
    logic rd_out_load;
    logic [9:0] wr_ptr;
    logic [9:0] rd_ptr;
    logic [9:0] next_wr_ptr;
    logic [9:0] next_rd_ptr;
    logic [9:0] fill;
    logic [9:0] next_fill;
    ebf_stream_if #(.W(`EBF_DATA_W)) stage ();

    ////////////////////////////////////////////////////////////////
    // mode is static configuration, held in a register
    always_ff @(posedge mclk) begin
        if (reset) begin
            mode_r <= ebf_pkg::ebf_single;
        end else if (clk_en) begin
            mode_r <= ebf_pkg::ebf_mode_t'(mode_sel);
        end
    end

    ////////////////////////////////////////////////////////////////
    // port clocks arrive from foreign domains, so they are synchronised
    // and only their rising edges are used; a port clock must stay
    // below a quarter of mclk or edges are lost
    ebf_sync3 #(.W(4)) u_sync (
        .mclk(mclk),
        .reset(reset),
        .clk_en(clk_en),
        .pin({rd_clk, wr_clk, b_clk, a_clk}),
        .level(pin_level)
    );

    // rising edge of each agreed port clock level
    always_ff @(posedge mclk) begin
        if (reset) begin
            pin_prev <= '0;
        end else if (clk_en) begin
            pin_prev <= pin_level;
        end
    end
    assign pin_edge = pin_level & ~pin_prev;
    assign p_edge = pin_edge[1:0];
    assign wr_edge = pin_edge[2];
    assign rd_edge = pin_edge[3];

    ////////////////////////////////////////////////////////////////
    // ports A and B gathered into arrays for the per-port loop
    assign p_ce = {b_ce, a_ce};
    assign p_out_en = {b_output_reg_clk_en, a_output_reg_clk_en};
    assign p_rst = {b_rst, a_rst};
    assign p_we = {b_we, a_we};
    assign p_cs = {b_cs, a_cs};
    assign p_be = {b_byte_lane_en, a_byte_lane_en};
    assign p_addr = {b_addr, a_addr};
    assign p_din = {b_write_data, a_write_data};
    assign fifo_mode = (mode_r == ebf_pkg::ebf_fifo);

    // which port may do what in each mode; pseudo dual writes on A, reads on B
    always_comb begin
        unique case (mode_r)
            ebf_pkg::ebf_single: begin
                port_wr = 2'h1;
                port_rd = 2'h1;
            end
            ebf_pkg::ebf_true_dual: begin
                port_wr = 2'h3;
                port_rd = 2'h3;
            end
            ebf_pkg::ebf_pseudo_dual: begin
                port_wr = 2'h1;
                port_rd = 2'h2;
            end
            ebf_pkg::ebf_fifo: begin
                port_wr = 2'h0;
                port_rd = 2'h0;
            end
        endcase
        port_on = port_wr | port_rd;
    end

    ////////////////////////////////////////////////////////////////
    // per-port pipeline: input register, array access, output register
    for (genvar p = 0; p < 2; p++) begin : g_port
        logic req_v;
        ebf_pkg::ebf_req_t req;
        logic out_go;
        logic [17:0] dout;
        // an edge with clock enable low or a wrong select is ignored
        always_ff @(posedge mclk) begin
            if (reset) begin
                req_v <= 1'b0;
                req <= '0;
            end else if (clk_en) begin
                req_v <= p_edge[p] & p_ce[p] & (p_cs[p] == `EBF_CS_MATCH) & port_on[p];
                if (p_edge[p]) begin
                    req <= '{we: p_we[p] & port_wr[p], out_en: p_out_en[p], be: p_be[p],
                             addr: p_addr[p], din: p_din[p]};
                end
            end
        end
        // output register loads only with its output clock enable
        always_ff @(posedge mclk) begin
            if (reset) begin
                out_go <= 1'b0;
                dout <= '0;
            end else if (clk_en) begin
                out_go <= req_v & req.out_en & port_rd[p];
                if (p_rst[p]) begin
                    dout <= '0;
                end else if (out_go) begin
                    dout <= port_raw[p];
                end
            end
        end
    end
    assign a_dout = g_port[0].dout;
    assign b_dout = g_port[1].dout;

    ////////////////////////////////////////////////////////////////
    // array split into byte lanes so each lane writes on its own enable;
    // port A is applied last, so it wins a same-address collision
    for (genvar l = 0; l < `EBF_LANES; l++) begin : g_lane
        logic [LW-1:0] lane_mem [`EBF_DEPTH];
        logic [LW-1:0] fifo_q;
        always_ff @(posedge mclk) begin
            if (clk_en) begin
                if (fifo_wr_go) begin
                    lane_mem[wr_ptr[8:0]] <= write_data[l*LW +: LW];
                end
                if (g_port[1].req_v && g_port[1].req.we && g_port[1].req.be[l]) begin
                    lane_mem[g_port[1].req.addr] <= g_port[1].req.din[l*LW +: LW];
                end
                if (g_port[0].req_v && g_port[0].req.we && g_port[0].req.be[l]) begin
                    lane_mem[g_port[0].req.addr] <= g_port[0].req.din[l*LW +: LW];
                end
            end
        end
        // reads return the word as it stood before a write in the same cycle
        always_ff @(posedge mclk) begin
            if (clk_en && fifo_rd_go) begin
                fifo_q <= lane_mem[rd_ptr[8:0]];
            end
        end
        assign fifo_raw[l*LW +: LW] = fifo_q;
        for (genvar p = 0; p < 2; p++) begin : g_rd
            logic [LW-1:0] rd_q;
            always_ff @(posedge mclk) begin
                if (clk_en && g_port[p].req_v) begin
                    rd_q <= lane_mem[g_port[p].req.addr];
                end
            end
            assign port_raw[p][l*LW +: LW] = rd_q;
        end
    end

    ////////////////////////////////////////////////////////////////
    // fifo access decode; the gate inputs sit in bit 2 of each select
    assign wr_cs_ok = ({full_in_gate, wr_port_select} == `EBF_CSW_MATCH);
    assign rd_cs_ok = ({empty_in_gate, rd_port_select} == `EBF_CSR_MATCH);
    assign fifo_wr_go = fifo_mode & wr_edge & wr_cs_ok & fifo_we & ~full_flag;
    // a read also waits for room in the staging buffer, so a slow
    // consumer stalls the read side instead of losing words
    assign fifo_rd_go = fifo_mode & rd_edge & rd_cs_ok & fifo_re & ~empty_flag
                        & stage.in_ready & ~rd_pend;

    // pointer updates; the read pointer reset leaves the write pointer alone
    always_comb begin
        next_wr_ptr = wr_ptr + 10'(fifo_wr_go);
        next_rd_ptr = rd_ptr + 10'(fifo_rd_go);
        if (rd_ptr_reset) begin
            next_rd_ptr = '0;
        end
        next_fill = next_wr_ptr - next_rd_ptr;
    end
    assign fill = wr_ptr - rd_ptr;
    always_ff @(posedge mclk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (clk_en) begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
        end
    end
    // flags are registered from the next pointers, so they match fill
    always_ff @(posedge mclk) begin
        if (reset) begin
            full_flag <= 1'b0;
            almost_full_flag <= 1'b0;
            empty_flag <= 1'b1;
            almost_empty_flag <= 1'b1;
        end else if (clk_en) begin
            full_flag <= (next_fill >= `EBF_FULL_LEVEL);
            almost_full_flag <= (next_fill >= af_level);
            empty_flag <= (next_fill == '0);
            almost_empty_flag <= (next_fill <= ae_level);
        end
    end

    ////////////////////////////////////////////////////////////////
    // read data staging: array word pushed one cycle after the read
    always_ff @(posedge mclk) begin
        if (reset) begin
            rd_pend <= 1'b0;
        end else if (clk_en) begin
            rd_pend <= fifo_rd_go;
        end
    end
    assign stage.in_valid = rd_pend;
    assign stage.in_data = fifo_raw;

    ebf_stream_fifo #(.WIDTH(`EBF_DATA_W), .DEPTH(`EBF_BUF_DEPTH)) u_stage (
        .mclk(mclk),
        .reset(reset),
        .clk_en(clk_en),
        .s(stage)
    );

    // output register moves only on a selected read edge with out_read_en
    assign rd_out_load = fifo_mode & rd_edge & rd_cs_ok & out_read_en & stage.out_valid;
    assign stage.out_ready = rd_out_load;
    always_ff @(posedge mclk) begin
        if (reset) begin
            read_data <= '0;
            read_valid <= 1'b0;
        end else if (clk_en) begin
            read_valid <= rd_out_load;
            if (rd_out_load) begin
                read_data <= stage.out_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // checks; a refused access must leave its pointer untouched
    property p_full_blocks;
        @(posedge mclk) disable iff (reset) (clk_en && full_flag) |=> $stable(wr_ptr);
    endproperty
    a_full_blocks: assert property (p_full_blocks) else $error("write taken while full");
    property p_full_gate;
        @(posedge mclk) disable iff (reset) (clk_en && full_in_gate) |=> $stable(wr_ptr);
    endproperty
    a_full_gate: assert property (p_full_gate) else $error("write taken with full gate");
    property p_empty_gate;
        @(posedge mclk) disable iff (reset) (clk_en && empty_in_gate && !rd_ptr_reset) |=> $stable(rd_ptr);
    endproperty
    a_empty_gate: assert property (p_empty_gate) else $error("read taken with empty gate");
    property p_wr_select;
        @(posedge mclk) disable iff (reset) (clk_en && wr_port_select != 2'h3) |=> $stable(wr_ptr);
    endproperty
    a_wr_select: assert property (p_wr_select) else $error("write taken while deselected");
    property p_full_level;
        @(posedge mclk) disable iff (reset) full_flag == (fill >= `EBF_FULL_LEVEL);
    endproperty
    a_full_level: assert property (p_full_level) else $error("full flag disagrees with fill");
    property p_empty_level;
        @(posedge mclk) disable iff (reset) empty_flag == (fill == 10'h000);
    endproperty
    a_empty_level: assert property (p_empty_level) else $error("empty flag disagrees with fill");
    property p_rd_ptr_reset;
        @(posedge mclk) disable iff (reset)
            (clk_en && rd_ptr_reset && !fifo_wr_go) |=> (rd_ptr == 10'h000) && $stable(wr_ptr);
    endproperty
    a_rd_ptr_reset: assert property (p_rd_ptr_reset) else $error("pointer reset misbehaved");
    property p_out_hold;
        @(posedge mclk) disable iff (reset) !(clk_en && rd_out_load) |=> $stable(read_data);
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("read data moved without load");
    property p_ce_gates;
        @(posedge mclk) disable iff (reset) (clk_en && p_edge[0] && !a_ce) |=> !g_port[0].req_v;
    endproperty
    a_ce_gates: assert property (p_ce_gates) else $error("port A access with ce low");
    property p_single_no_b;
        @(posedge mclk) disable iff (reset)
            ($stable(mode_r) && mode_r == ebf_pkg::ebf_single) |-> !g_port[1].req_v;
    endproperty
    a_single_no_b: assert property (p_single_no_b) else $error("port B active in single mode");
endmodule

/* ebf_port_clk_model.sv */
`timescale 1ns/100ps
////////////////////////////////////////////////////////////
// user-side port clock source: one rising edge per request, held high and low
// long enough for the block's three-stage input synchroniser to see it
module ebf_port_clk_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic go,
    output logic pclk,
    output logic busy
);
    logic [3:0] cnt;
    ////////////////////////////////////////////////////////////
    // eight-cycle frame: four high then four low, so edges sit well apart
    always_ff @(posedge mclk) begin
        if (reset) begin
            cnt <= 4'h0;
        end else if (go && cnt == 4'h0) begin
            cnt <= 4'h8;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end
    end
    // clock rests low outside frames; only its rising edge carries meaning
    assign pclk = cnt > 4'h4;
    assign busy = cnt != 4'h0;
endmodule

/* ebf_block_ram_tb.sv */
`timescale 1ns/100ps
module ebf_block_ram_tb;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic clk_en = 1'b1;
    logic [1:0] mode_sel = 2'h0;
    logic a_ce = 1'b0, a_output_reg_clk_en = 1'b0, a_rst = 1'b0, a_we = 1'b0;
    logic b_ce = 1'b0, b_output_reg_clk_en = 1'b0, b_rst = 1'b0, b_we = 1'b0;
    logic [2:0] a_cs = 3'h0, b_cs = 3'h0;
    logic [1:0] a_byte_lane_en = 2'h0, b_byte_lane_en = 2'h0;
    logic [8:0] a_addr = 9'h000, b_addr = 9'h000;
    logic [17:0] a_write_data = 18'h00000, b_write_data = 18'h00000, write_data = 18'h00000;
    logic [1:0] wr_port_select = 2'h0, rd_port_select = 2'h0;
    logic full_in_gate = 1'b0, empty_in_gate = 1'b0, fifo_we = 1'b0, fifo_re = 1'b0;
    logic out_read_en = 1'b0, rd_ptr_reset = 1'b0;
    logic [9:0] af_level = 10'h1F0, ae_level = 10'h003;
    logic [17:0] a_dout, b_dout, read_data;
    logic read_valid, full_flag, almost_full_flag, empty_flag, almost_empty_flag;
    logic [3:0] go = 4'h0;
    logic [3:0] pclk, busy;
    logic [17:0] sh [0:511];
    logic [17:0] fw [0:511];
    logic [9:0] wptr = 10'h000, rptr = 10'h000, oidx = 10'h000;
    int staged = 0, vcnt = 0, vexp = 0, err_total = 0, checked = 0;
    logic [31:0] seed = 32'hB08CEF6A;
    wire [17:0] flag_seen = {14'h0000, full_flag, almost_full_flag, empty_flag, almost_empty_flag};

    always #2.5 mclk = ~mclk;

    ////////////////////////////////////////////////////////////
    // port clock sources: a, b, write side, read side
    for (genvar k = 0; k < 4; k++) begin : g_pc
        ebf_port_clk_model i_pc (.mclk(mclk), .reset(reset), .go(go[k]), .pclk(pclk[k]), .busy(busy[k]));
    end

    ebf_block_ram i_dut (.mclk, .reset, .clk_en, .mode_sel, .a_clk(pclk[0]), .a_ce, .a_output_reg_clk_en, .a_rst,
        .a_we, .a_cs, .a_byte_lane_en, .a_addr, .a_write_data, .a_dout, .b_clk(pclk[1]), .b_ce,
        .b_output_reg_clk_en, .b_rst, .b_we, .b_cs, .b_byte_lane_en, .b_addr, .b_write_data, .b_dout,
        .wr_clk(pclk[2]), .rd_clk(pclk[3]), .wr_port_select, .full_in_gate, .rd_port_select, .empty_in_gate,
        .fifo_we, .fifo_re, .write_data, .out_read_en, .rd_ptr_reset, .af_level, .ae_level, .read_data,
        .read_valid, .full_flag, .almost_full_flag, .empty_flag, .almost_empty_flag);

    ////////////////////////////////////////////////////////////
    // expectation helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [17:0] merge(input logic [17:0] o, input logic [17:0] n, input logic [1:0] be);
        return {be[1] ? n[17:9] : o[17:9], be[0] ? n[8:0] : o[8:0]};
    endfunction

    // fill is the pointer difference, so it stays right across the wrap at 1024
    function automatic logic [17:0] flags_exp();
        logic [9:0] fill;
        fill = wptr - rptr;
        return {14'h0000, fill >= 10'h200, fill >= af_level, fill == 10'h000, fill <= ae_level};
    endfunction

    task automatic check(input logic [17:0] seen, input logic [17:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////
    // one port clock frame; inputs stay put until the frame has run out
    task automatic pulse(input int k);
        int n;
        @(posedge mclk);
        go[k] <= 1'b1;
        @(posedge mclk);
        go[k] <= 1'b0;
        @(posedge mclk);
        for (n = 0; n < 16 && busy[k] === 1'b1; n++) @(posedge mclk);
    endtask

    task automatic ram(input int p, input logic we, input logic oen, input logic [1:0] be, input logic [8:0] ad,
                       input logic [17:0] d, input logic [2:0] cs);
        if (p == 1) begin
            {b_ce, b_we, b_output_reg_clk_en, b_byte_lane_en} <= {1'b1, we, oen, be};
            {b_addr, b_write_data, b_cs} <= {ad, d, cs};
        end else begin
            {a_ce, a_we, a_output_reg_clk_en, a_byte_lane_en} <= {1'b1, we, oen, be};
            {a_addr, a_write_data, a_cs} <= {ad, d, cs};
        end
        pulse(p);
    endtask

    task automatic fwr(input logic [17:0] d, input logic gate, input logic [1:0] sel);
        logic ok;
        ok = mode_sel == 2'h3 && !gate && sel == 2'h3 && (wptr - rptr) < 10'h200;
        {write_data, fifo_we, full_in_gate, wr_port_select} <= {d, 1'b1, gate, sel};
        pulse(2);
        if (ok) begin
            fw[wptr[8:0]] = d;
            wptr = wptr + 10'h001;
        end
        check(flag_seen, flags_exp());
    endtask

    // output uses a word staged before this edge; the pull refills staging after
    task automatic frd(input logic re, input logic take, input logic gate);
        logic out_ok, pull_ok;
        out_ok = take && !gate && staged > 0;
        pull_ok = re && !gate && wptr != rptr && staged < 4;
        {fifo_re, out_read_en, empty_in_gate, rd_port_select} <= {re, take, gate, 2'h3};
        pulse(3);
        if (out_ok) begin
            staged--;
            vexp++;
        end
        if (pull_ok) begin
            staged++;
            rptr = rptr + 10'h001;
        end
        check(18'(vcnt), 18'(vexp));
        check(flag_seen, flags_exp());
    endtask

    // every loaded word must come out in write order
    always @(posedge mclk) begin
        if (read_valid === 1'b1) begin
            check(read_data, fw[oidx[8:0]]);
            oidx = oidx + 10'h001;
            vcnt++;
        end
    end

    ////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        logic [31:0] r;
        logic [8:0] ad;
        logic [17:0] d;
        repeat (8) @(posedge mclk);
        reset <= 1'b0;
        repeat (4) @(posedge mclk);
        check(a_dout, 18'h00000);
        check(read_data, 18'h00000);
        check(flag_seen, flags_exp());
        // single port: full word, then a lane-masked write, then read back
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            ad = r[8:0];
            ram(0, 1'b1, 1'b0, 2'h3, ad, r[31:14], 3'h7);
            sh[ad] = r[31:14];
            r = rnd();
            ram(0, 1'b1, 1'b0, i[1:0], ad, r[17:0], 3'h7);
            sh[ad] = merge(sh[ad], r[17:0], i[1:0]);
            ram(0, 1'b0, 1'b1, 2'h0, ad, 18'h00000, 3'h7);
            check(a_dout, sh[ad]);
        end
        ram(0, 1'b1, 1'b0, 2'h3, ad, ~sh[ad], 3'h6);
        // same write again, first with ce low, then frozen by clk_en; neither may land
        a_cs <= 3'h7;
        a_ce <= 1'b0;
        pulse(0);
        clk_en <= 1'b0;
        a_ce <= 1'b1;
        pulse(0);
        clk_en <= 1'b1;
        ram(0, 1'b0, 1'b0, 2'h0, ad ^ 9'h001, 18'h00000, 3'h7);
        check(a_dout, sh[ad]);
        ram(0, 1'b0, 1'b1, 2'h0, ad, 18'h00000, 3'h7);
        check(a_dout, sh[ad]);
        ram(1, 1'b0, 1'b1, 2'h0, ad, 18'h00000, 3'h7);
        check(b_dout, 18'h00000);
        // true dual: b writes, both ports read
        mode_sel <= 2'h1;
        r = rnd();
        d = r[17:0];
        ram(1, 1'b1, 1'b0, 2'h3, ad, d, 3'h7);
        ram(0, 1'b0, 1'b1, 2'h0, ad, 18'h00000, 3'h7);
        check(a_dout, d);
        ram(1, 1'b0, 1'b1, 2'h0, ad, 18'h00000, 3'h7);
        check(b_dout, d);
        // pseudo dual: a writes only, b reads only
        mode_sel <= 2'h2;
        r = rnd();
        ram(0, 1'b1, 1'b0, 2'h3, ad, r[17:0], 3'h7);
        ram(1, 1'b1, 1'b0, 2'h3, ad, ~r[17:0], 3'h7);
        ram(1, 1'b0, 1'b1, 2'h0, ad, 18'h00000, 3'h7);
        check(b_dout, r[17:0]);
        ram(0, 1'b0, 1'b1, 2'h0, ad, 18'h00000, 3'h7);
        check(a_dout, d);
        // port reset clears the output register
        a_rst <= 1'b1;
        @(posedge mclk);
        a_rst <= 1'b0;
        @(posedge mclk);
        check(a_dout, 18'h00000);
        // buffer mode: refused writes, gated and held reads
        mode_sel <= 2'h3;
        @(posedge mclk);
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            fwr(r[17:0], 1'b0, 2'h3);
        end
        fwr(18'h15555, 1'b1, 2'h3);
        fwr(18'h2AAAA, 1'b0, 2'h1);
        repeat (3) frd(1'b1, 1'b1, 1'b0);
        frd(1'b0, 1'b1, 1'b0);
        frd(1'b1, 1'b0, 1'b0);
        frd(1'b0, 1'b1, 1'b1);
        frd(1'b1, 1'b1, 1'b1);
        frd(1'b0, 1'b1, 1'b0);
        // read pointer alone returns to start; the words are read again
        rd_ptr_reset <= 1'b1;
        @(posedge mclk);
        rd_ptr_reset <= 1'b0;
        rptr = 10'h000;
        oidx = 10'h000;
        repeat (3) @(posedge mclk);
        check(flag_seen, flags_exp());
        while (wptr != 10'h200) begin
            r = rnd();
            fwr(r[17:0], 1'b0, 2'h3);
        end
        fwr(18'h3FFFF, 1'b0, 2'h3);
        while (wptr != rptr) frd(1'b1, 1'b1, 1'b0);
        frd(1'b0, 1'b1, 1'b0);
        check(18'(oidx), 18'h00200);
        stop_test();
    end

    // hang guard, sized well above the roughly 12000 cycles the sequence needs
    initial begin
        repeat (40000) @(posedge mclk);
        err_total++;
        stop_test();
    end
endmodule
